// File: design/twm_defs.vh
`ifndef TWM_DEFS_VH
`define TWM_DEFS_VH

// Register byte offsets
`define TWM_OFF_CTRL      8'h00
`define TWM_OFF_COUNT     8'h04
`define TWM_OFF_COMPARE   8'h08
`define TWM_OFF_STATUS    8'h0C
`define TWM_OFF_PORT      8'h10

// Control register fields
`define TWM_CTRL_WGM_LSB  0
`define TWM_CTRL_WGM_MSB  1
`define TWM_CTRL_COM_LSB  2
`define TWM_CTRL_COM_MSB  3
`define TWM_CTRL_FORCE    4

// Status register fields
`define TWM_STAT_OVF      0
`define TWM_STAT_CMP      1

// Port register fields
`define TWM_PORT_VAL      0
`define TWM_PORT_DIR      1

// Waveform modes
`define TWM_WGM_NORMAL    2'h0
`define TWM_WGM_PHASE     2'h1
`define TWM_WGM_CTC       2'h2
`define TWM_WGM_FAST      2'h3

// Compare output actions
`define TWM_COM_OFF       2'h0
`define TWM_COM_TOGGLE    2'h1
`define TWM_COM_CLEAR     2'h2
`define TWM_COM_SET       2'h3

// Counter extremes and reset values
`define TWM_CNT_MAX       8'hFF
`define TWM_CNT_BOTTOM    8'h00
`define TWM_RST_BYTE      8'h00
`define TWM_RST_CTRL      4'h0

`endif

// File: design/twm_timer8.v
// Functional notes
// (R1) Compare output mode picks the match action and the pin source.
// (R2) Reset clears the internal compare output state to zero.
// (R3) Nonzero compare output mode puts the state on the pin; direction bit still gates.
// (R4) Pin override depends only on compare output mode, never on waveform mode.
// (R5) State can be set up while the pin driver is still off.
// (R6) Compare output mode zero leaves the state unchanged at matches.
// (R7) New compare output mode acts at next match; force applies it at once.
// (R8) Waveform mode alone decides the counting sequence.
// (R9) Mode zero always counts up and wraps from FF to 00.
// (R10) Mode zero sets overflow flag when counter becomes zero; only cleared elsewhere.
// (R11) Mode zero accepts a counter write at any time.
// (R12) Mode two clears the counter when it equals the compare value.
// (R13) Mode two compare value is unbuffered; low writes wait for wrap.
// (R14) Mode two raises the compare flag every period at the top value.
// (R15) Mode two with action one toggles the state on every match.
// (R16) Mode two sets overflow flag when counter advances from FF to 00; a compare match at FF clears the counter without setting it.
// (R17) Mode three counts zero to max, then clears and repeats.
// (R18) Mode three: action two clears at match, sets at bottom; three inverts.
// (R19) Mode three sets overflow flag each time the counter is at max.
// (R20) Mode three gives one period every 256 timer ticks.
// (R21) Mode three: compare zero gives spike, compare max gives constant level.
// (R22) Mode three with action one toggles on match with buffered compare.
// (R23) Mode three buffers compare writes until bottom; mode one never loads them; modes zero and two write directly.
// (R24) Force strobe in non-PWM modes acts as a match without flag or clear.
// (R25) Compare flag sets one tick after equality; cleared by one-write or acknowledge.
// (R26) All updates run on mclk and advance only on timer tick enable; bus writes, the force strobe and flag clears act without a tick.
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "twm_defs.vh"

module twm_timer8 #(
  parameter CNT_W = 8
) (
  input  wire              mclk,
  input  wire              reset,
  input  wire              timer_tick,
  input  wire              overflow_ack,
  input  wire              compare_ack,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [7:0]        paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  output reg               pin_out,
  output reg               pin_oe_n,
  output reg               compare_output_state,
  output reg               overflow_flag,
  output reg               compare_flag
);

  // Register state
  reg [1:0]       waveform_mode_q;
  reg [1:0]       compare_output_mode_q;
  reg [CNT_W-1:0] counter_value_q;
  reg [CNT_W-1:0] counter_value_d;
  reg [CNT_W-1:0] compare_value_q;
  reg [CNT_W-1:0] compare_buf_q;
  reg             port_val_q;
  reg             output_pin_direction_q;
  reg             block_q;
  reg             match_seen_q;
  reg             oc_d;
  reg             ovf_set;

  // Candidate next states from the force and tick actions
  reg             force_val;
  reg             tick_val;
  reg [31:0]      rdata_d;
  reg             addr_ok;

  // Transfer phases
  wire setup_ph   = psel & ~penable;
  wire access_ph  = psel & penable & pready;
  wire wr_en      = access_ph & pwrite & ~pslverr;

  // Register write strobes
  wire wr_ctrl    = wr_en & (paddr == `TWM_OFF_CTRL);
  wire wr_count   = wr_en & (paddr == `TWM_OFF_COUNT);
  wire wr_cmp     = wr_en & (paddr == `TWM_OFF_COMPARE);
  wire wr_stat    = wr_en & (paddr == `TWM_OFF_STATUS);
  wire wr_port    = wr_en & (paddr == `TWM_OFF_PORT);

  // Mode decode
  wire is_fast    = (waveform_mode_q == `TWM_WGM_FAST);
  wire is_pwm     = waveform_mode_q[0];
  wire at_max     = (counter_value_q == `TWM_CNT_MAX);

  // Compare match, masked for one tick after a counter write
  wire match_raw  = (counter_value_q == compare_value_q);
  wire match      = timer_tick & match_raw & ~block_q;

  // Force strobe acts only outside PWM modes
  wire force_hit  = wr_ctrl & pwdata[`TWM_CTRL_FORCE] & ~is_pwm; // (R24)
  wire [1:0] com_new = pwdata[`TWM_CTRL_COM_MSB:`TWM_CTRL_COM_LSB];

  // Overflow event, dropped when a counter write lands on the same edge
  wire ovf_evt    = ovf_set & ~wr_count;

  // Address check and read mux
  always @* begin
    addr_ok = 1'b1;
    rdata_d = 32'h0000_0000;
    case (paddr)
      `TWM_OFF_CTRL: begin
        rdata_d[`TWM_CTRL_WGM_MSB:`TWM_CTRL_WGM_LSB] = waveform_mode_q;
        rdata_d[`TWM_CTRL_COM_MSB:`TWM_CTRL_COM_LSB] = compare_output_mode_q;
      end
      `TWM_OFF_COUNT: begin
        rdata_d[CNT_W-1:0] = counter_value_q;
      end
      `TWM_OFF_COMPARE: begin
        rdata_d[CNT_W-1:0] = compare_buf_q;
      end
      `TWM_OFF_STATUS: begin
        rdata_d[`TWM_STAT_OVF] = overflow_flag;
        rdata_d[`TWM_STAT_CMP] = compare_flag;
      end
      `TWM_OFF_PORT: begin
        rdata_d[`TWM_PORT_VAL] = port_val_q;
        rdata_d[`TWM_PORT_DIR] = output_pin_direction_q;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // Ready pulse: no wait state, high in the first access cycle
  always @(posedge mclk) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_ph;
    end
  end

  // Error answer for unmapped offsets, valid with ready
  always @(posedge mclk) begin
    if (reset) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_ph & ~addr_ok;
    end
  end

  // Read data captured in the setup cycle, held until the next setup
  always @(posedge mclk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata <= pwrite ? 32'h0000_0000 : rdata_d;
    end
  end

  // Mode fields; the force bit is a strobe and is not stored
  always @(posedge mclk) begin
    if (reset) begin
      waveform_mode_q       <= 2'h0;
      compare_output_mode_q <= `TWM_COM_OFF;
    end else if (wr_ctrl) begin
      waveform_mode_q       <= pwdata[`TWM_CTRL_WGM_MSB:`TWM_CTRL_WGM_LSB]; // (R8)
      compare_output_mode_q <= com_new; // (R7)
    end
  end

  // Port value and direction bits
  always @(posedge mclk) begin
    if (reset) begin
      port_val_q             <= 1'b0;
      output_pin_direction_q <= 1'b0;
    end else if (wr_port) begin
      port_val_q             <= pwdata[`TWM_PORT_VAL];
      output_pin_direction_q <= pwdata[`TWM_PORT_DIR];
    end
  end

  // Next counter value and overflow event per waveform mode
  always @* begin
    counter_value_d = counter_value_q;
    ovf_set         = 1'b0;
    if (timer_tick) begin
      case (waveform_mode_q)
        `TWM_WGM_NORMAL: begin
          counter_value_d = counter_value_q + 1'b1; // (R9)
          ovf_set         = at_max;                 // (R10)
        end
        `TWM_WGM_CTC: begin
          if (match) begin
            counter_value_d = `TWM_CNT_BOTTOM;      // (R12)
          end else begin
            counter_value_d = counter_value_q + 1'b1; // (R13)
          end
          ovf_set = at_max & ~match;                // (R16)
        end
        `TWM_WGM_FAST: begin
          counter_value_d = counter_value_q + 1'b1; // (R17) (R20)
          ovf_set         = at_max;                 // (R19)
        end
        default: begin
          counter_value_d = counter_value_q;
        end
      endcase
    end
  end

  // Counter: bus write wins over counting
  always @(posedge mclk) begin
    if (reset) begin
      counter_value_q <= `TWM_RST_BYTE;
    end else if (wr_count) begin
      counter_value_q <= pwdata[CNT_W-1:0]; // (R11)
    end else begin
      counter_value_q <= counter_value_d; // (R26)
    end
  end

  // Match blocking: a counter write masks the match of the next tick
  always @(posedge mclk) begin
    if (reset) begin
      block_q <= 1'b0;
    end else if (wr_count) begin
      block_q <= 1'b1;
    end else if (timer_tick) begin
      block_q <= 1'b0;
    end
  end

  // Software view of the compare value
  always @(posedge mclk) begin
    if (reset) begin
      compare_buf_q <= `TWM_RST_BYTE;
    end else if (wr_cmp) begin
      compare_buf_q <= pwdata[CNT_W-1:0];
    end
  end

  // Active compare: direct outside PWM, loaded at max in fast PWM
  always @(posedge mclk) begin
    if (reset) begin
      compare_value_q <= `TWM_RST_BYTE;
    end else if (wr_cmp & ~is_pwm) begin
      compare_value_q <= pwdata[CNT_W-1:0]; // (R23) (R13)
    end else if (is_fast & timer_tick & at_max) begin
      compare_value_q <= compare_buf_q; // (R23) (R22)
    end
  end

  // Waveform events seen by the output unit
  wire match_act  = match & (is_fast | ~is_pwm); // Mode one takes no action
  wire bottom_act = is_fast & at_max;            // Counter leaves max this tick

  // Force action, decoded from the mode written with the strobe
  always @* begin
    force_val = compare_output_state;
    case (com_new)
      `TWM_COM_TOGGLE: force_val = ~compare_output_state; // (R24) (R7)
      `TWM_COM_CLEAR:  force_val = 1'b0;
      `TWM_COM_SET:    force_val = 1'b1;
      default:         force_val = compare_output_state; // (R6)
    endcase
  end

  // Tick action from the stored mode; bottom wins over match
  always @* begin
    tick_val = compare_output_state;
    case (compare_output_mode_q) // (R1)
      `TWM_COM_TOGGLE: begin
        if (match_act) begin
          tick_val = ~compare_output_state; // (R15) (R22)
        end
      end
      `TWM_COM_CLEAR: begin
        if (bottom_act) begin
          tick_val = 1'b1; // (R18) (R21)
        end else if (match_act) begin
          tick_val = 1'b0;
        end
      end
      `TWM_COM_SET: begin
        if (bottom_act) begin
          tick_val = 1'b0; // (R18) (R21)
        end else if (match_act) begin
          tick_val = 1'b1;
        end
      end
      default: begin
        tick_val = compare_output_state; // (R6)
      end
    endcase
  end

  // Next state: force strobe first, then timer tick actions
  always @* begin
    if (force_hit) begin
      oc_d = force_val;
    end else if (timer_tick) begin
      oc_d = tick_val;
    end else begin
      oc_d = compare_output_state;
    end
  end

  // State register, kept across mode changes and pin direction
  always @(posedge mclk) begin
    if (reset) begin
      compare_output_state <= 1'b0; // (R2)
    end else begin
      compare_output_state <= oc_d; // (R5)
    end
  end

  // Match remembered for one tick; the flag follows on the next tick
  always @(posedge mclk) begin
    if (reset) begin
      match_seen_q <= 1'b0;
    end else if (timer_tick) begin
      match_seen_q <= match;
    end
  end

  // Overflow flag: hardware set wins over clears
  always @(posedge mclk) begin
    if (reset) begin
      overflow_flag <= 1'b0;
    end else if (ovf_evt) begin
      overflow_flag <= 1'b1; // (R10)
    end else if (overflow_ack | (wr_stat & pwdata[`TWM_STAT_OVF])) begin
      overflow_flag <= 1'b0;
    end
  end

  // Compare flag: hardware set wins over clears
  always @(posedge mclk) begin
    if (reset) begin
      compare_flag <= 1'b0;
    end else if (timer_tick & match_seen_q) begin
      compare_flag <= 1'b1; // (R25) (R14)
    end else if (compare_ack | (wr_stat & pwdata[`TWM_STAT_CMP])) begin
      compare_flag <= 1'b0; // (R25)
    end
  end

  // Next mode and port value, so the pin follows a write on the same edge
  wire [1:0] com_mode_d = wr_ctrl ? com_new : compare_output_mode_q;
  wire       port_val_d = wr_port ? pwdata[`TWM_PORT_VAL] : port_val_q;

  // Pin source: compare output state overrides the port value
  always @(posedge mclk) begin
    if (reset) begin
      pin_out <= 1'b0;
    end else if (com_mode_d != `TWM_COM_OFF) begin
      pin_out <= oc_d; // (R3) (R4)
    end else begin
      pin_out <= port_val_d;
    end
  end

  // Driver enable follows the direction bit only
  always @(posedge mclk) begin
    if (reset) begin
      pin_oe_n <= 1'b1;
    end else begin
      pin_oe_n <= ~output_pin_direction_q; // (R3)
    end
  end

endmodule

`default_nettype wire

// File: bench/twm_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module twm_pin_model (
  input  wire logic mclk,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output wire logic pin_level
);
  logic last_q;
  // Remember the last driven level
  always_ff @(posedge mclk) begin
    if (!pin_oe_n) last_q <= pin_out;
  end
  // Released pin drifts away from the old level
  assign pin_level = !pin_oe_n ? pin_out : !last_q;
endmodule
`default_nettype wire

// File: bench/twm_timer8_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "twm_defs.vh"
module twm_timer8_asserts (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        timer_tick,
  input wire logic        overflow_ack,
  input wire logic        compare_ack,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pin_oe_n,
  input wire logic        compare_output_state,
  input wire logic        overflow_flag,
  input wire logic        compare_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic wr_acc;
  logic st_wr;
  // Committed writes
  assign wr_acc = psel & penable & pwrite & pready;
  assign st_wr = wr_acc & (paddr == `TWM_OFF_STATUS);
  property p_rst; $past(reset) |-> !compare_output_state && !overflow_flag && pin_oe_n; endproperty
  a_rst: assert property (p_rst) else $error("state not cleared by reset");
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_rdy_acc; pready |-> psel && penable; endproperty
  a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_oe; $changed(pin_oe_n) |-> $past(wr_acc && paddr == `TWM_OFF_PORT, 2); endproperty
  a_oe: assert property (p_oe) else $error("enable moved without port write");
  property p_ovf_set; $rose(overflow_flag) |-> $past(timer_tick); endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow set off tick");
  property p_cmp_set; $rose(compare_flag) |-> $past(timer_tick); endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("compare set off tick");
  property p_ovf_clr; $fell(overflow_flag) |-> $past(overflow_ack || (st_wr && pwdata[0])); endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow cleared by itself");
  property p_cmp_clr; $fell(compare_flag) |-> $past(compare_ack || (st_wr && pwdata[1])); endproperty
  a_cmp_clr: assert property (p_cmp_clr) else $error("compare cleared by itself");
  property p_state; $changed(compare_output_state) |-> $past(timer_tick || wr_acc); endproperty
  a_state: assert property (p_state) else $error("state moved without cause");
  c_ovf: cover property ($rose(overflow_flag));
  c_cmp: cover property ($rose(compare_flag));
  c_pin: cover property ($changed(compare_output_state) && !pin_oe_n);
endmodule
bind twm_timer8 twm_timer8_asserts u_chk (.mclk(mclk), .reset(reset), .timer_tick(timer_tick),
  .overflow_ack(overflow_ack), .compare_ack(compare_ack), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .pin_oe_n(pin_oe_n),
  .compare_output_state(compare_output_state), .overflow_flag(overflow_flag), .compare_flag(compare_flag));
`default_nettype wire

// File: bench/twm_timer8_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "twm_defs.vh"
module twm_timer8_test;
  logic        mclk, reset, timer_tick, overflow_ack, compare_ack, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, pin_out, pin_oe_n, cstate, ovf, cmpf, pin_level, rerr;
  int          err_count, num_checks;
  twm_timer8 DUT (.mclk(mclk), .reset(reset), .timer_tick(timer_tick), .overflow_ack(overflow_ack),
    .compare_ack(compare_ack), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .compare_output_state(cstate), .overflow_flag(ovf), .compare_flag(cmpf));
  twm_pin_model u_pin (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level));
  // Clock
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer, waits for ready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    #1;
    n = 0;
    while (pready !== 1'h1 && n < 16) begin
      @(posedge mclk);
      #1;
      n++;
    end
    // Ready and answer stand before the edge that commits the transfer
    rdat = prdata;
    rerr = pslverr;
    @(posedge mclk);
    psel <= 1'h0;
    penable <= 1'h0;
    #1;
    if (n >= 16) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(nm, exp, rdat);
  endtask
  // Exactly n timer ticks
  task automatic tick(input int n);
    @(posedge mclk);
    timer_tick <= 1'h1;
    repeat (n) @(posedge mclk);
    timer_tick <= 1'h0;
    #1;
  endtask
  initial begin
    {reset, timer_tick, overflow_ack, compare_ack, psel, penable, pwrite} = 7'h40;
    paddr = 8'h0;
    pwdata = 32'h0;
    err_count = 0;
    num_checks = 0;
    repeat (2) @(posedge mclk);
    reset <= 1'h0;
    #1;
    chk("state", 1'h0, cstate);
    chk("oe_n", 1'h1, pin_oe_n);
    rd("ctrl", `TWM_OFF_CTRL, 32'h0);
    apb(1'h0, 8'h20, 32'h0);
    chk("slverr", 1'h1, rerr);
    $display("test reset done");
    // Normal mode wrap and overflow
    wr(`TWM_OFF_COUNT, 32'hFE);
    tick(1);
    chk("ovf", 1'h0, ovf);
    tick(1);
    chk("ovf", 1'h1, ovf);
    rd("count", `TWM_OFF_COUNT, 32'h0);
    @(posedge mclk);
    overflow_ack <= 1'h1;
    @(posedge mclk);
    overflow_ack <= 1'h0;
    #1;
    chk("ovf", 1'h0, ovf);
    $display("test normal done");
    // Force strobe sets up state before the driver is on
    wr(`TWM_OFF_CTRL, 32'h14);
    chk("state", 1'h1, cstate);
    chk("oe_n", 1'h1, pin_oe_n);
    chk("cmpf", 1'h0, cmpf);
    wr(`TWM_OFF_PORT, 32'h3);
    wr(`TWM_OFF_CTRL, 32'h10);
    chk("state", 1'h1, cstate);
    chk("pin", 1'h1, pin_level);
    wr(`TWM_OFF_CTRL, 32'h18);
    chk("pin", 1'h0, pin_level);
    wr(`TWM_OFF_CTRL, 32'h1C);
    chk("state", 1'h1, cstate);
    wr(`TWM_OFF_CTRL, 32'h18);
    chk("state", 1'h0, cstate);
    $display("test force done");
    // Clear on match, toggle
    wr(`TWM_OFF_COMPARE, 32'h3);
    wr(`TWM_OFF_COUNT, 32'h0);
    wr(`TWM_OFF_CTRL, 32'h6);
    tick(4);
    chk("state", 1'h1, cstate);
    chk("cmpf", 1'h0, cmpf);
    tick(1);
    chk("cmpf", 1'h1, cmpf);
    rd("count", `TWM_OFF_COUNT, 32'h1);
    wr(`TWM_OFF_STATUS, 32'h2);
    chk("cmpf", 1'h0, cmpf);
    $display("test clear on match done");
    // Fast PWM, non-inverting
    wr(`TWM_OFF_CTRL, 32'h1A);
    chk("state", 1'h0, cstate);
    wr(`TWM_OFF_CTRL, 32'hB);
    wr(`TWM_OFF_COMPARE, 32'h2);
    wr(`TWM_OFF_COUNT, 32'hFF);
    tick(1);
    chk("ovf", 1'h1, ovf);
    chk("state", 1'h1, cstate);
    tick(3);
    chk("state", 1'h0, cstate);
    tick(252);
    chk("state", 1'h0, cstate);
    tick(1);
    chk("state", 1'h1, cstate);
    rd("count", `TWM_OFF_COUNT, 32'h0);
    $display("test fast pwm done");
    end_of_test();
  end
endmodule
`default_nettype wire
